//--- design/tas_pkg.sv
// Shared types and constants of the tilt angle signal core.
// Assumes one 50 MHz clock; continuous values are signed Q40.16 fixed point.
// Function
// - Discrete values held as 32-bit unsigned
// - Discrete to continuous keeps value, non-negative
// - Positive continuous to discrete truncates fraction
// - Too large continuous clamps to all ones
// - Negative continuous converts to discrete zero
// - Undefined stays undefined unless default configured
// - Accel block gives X, Y, Z, temperature
// - Temperature output in degrees Celsius
// - Sensor range 1.5, 3, 6 g, default 1.5
// - Higher ranges only on high-performance variants
// - Pitch spans 90 Euler, 180 unit rotation
// - Roll spans 180 in Euler and rotation
// - Tilt mode limit per tilt range, default 90
// - Gravity angle in degrees, 0 to 180
// - Angle type Euler/tilt/rotation, tilt default; Euler when strap_vertical is set
// - Gravity error above maximum gives error state
// - Max gravity error 0.05 to 0.5, default 0.2
// - Trust reads 0 when data valid
// - Trust 1 when temperature out of range
// - Trust 2 on sensor fault or error
// - Latency reported as continuous milliseconds
package tas_pkg;

	localparam int CW        = 56;
	localparam int FRAC      = 16;
	localparam int DW        = 32;
	localparam int IW        = CW - FRAC;

	typedef enum logic [1:0] {TAS_UNDEF, TAS_DISC, TAS_CONT} tas_kind_e;
	typedef enum logic [1:0] {TAS_RANGE_1G5, TAS_RANGE_3G, TAS_RANGE_6G}
		tas_range_e;
	typedef enum logic [1:0] {TAS_ANG_EULER, TAS_ANG_TILT, TAS_ANG_UNIT}
		tas_angle_e;
	typedef enum logic {TAS_TILT_90, TAS_TILT_180} tas_tilt_e;

	typedef logic signed [CW-1:0] tas_cont_t;
	typedef logic [DW-1:0]        tas_disc_t;

	typedef struct packed {
		tas_kind_e kind;
		tas_disc_t disc;
		tas_cont_t cont;
	} tas_sig_s;

	typedef struct packed {
		tas_range_e range;
		tas_angle_e angle_type;
		tas_tilt_e  tilt_range;
		tas_cont_t  max_err;
	} tas_cfg_s;

	typedef struct packed {
		tas_cont_t x;
		tas_cont_t y;
		tas_cont_t z;
		tas_cont_t temp;
	} tas_accel_s;

	typedef struct packed {
		tas_cont_t pitch;
		tas_cont_t roll;
		tas_cont_t grav;
		tas_cont_t grav_err;
	} tas_raw_s;

	// Q16 figures
	localparam tas_cont_t TAS_ANG_0     = 56'h00_0000_0000_0000;
	localparam tas_cont_t TAS_ANG_90    = 56'h00_0000_005A_0000;
	localparam tas_cont_t TAS_ANG_180   = 56'h00_0000_00B4_0000;
	localparam tas_cont_t TAS_TEMP_MIN  = -56'sh00_0000_0028_0000;
	localparam tas_cont_t TAS_TEMP_MAX  = 56'h00_0000_007D_0000;
	localparam tas_cont_t TAS_ERR_MIN   = 56'h00_0000_0000_0CCD;
	localparam tas_cont_t TAS_ERR_MAX   = 56'h00_0000_0000_8000;
	localparam tas_cont_t TAS_ERR_DFLT  = 56'h00_0000_0000_3333;
	localparam tas_disc_t TAS_DISC_MAX  = 32'hFFFF_FFFF;

	localparam tas_range_e TAS_RANGE_DFLT = TAS_RANGE_1G5;
	localparam tas_tilt_e  TAS_TILT_DFLT  = TAS_TILT_90;

	localparam tas_disc_t TAS_TRUST_OK      = 32'h0000_0000;
	localparam tas_disc_t TAS_TRUST_SUSPECT = 32'h0000_0001;
	localparam tas_disc_t TAS_TRUST_ERROR   = 32'h0000_0002;

	// Latency scaling: cycles to Q16 milliseconds
	localparam int CLK_PERIOD_NS = 20;
	localparam int NS_PER_MS     = 1000000;
	localparam int CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
	localparam longint LAT_MUL_L =
		((64'd1 << 32) + CYC_PER_MS / 2) / CYC_PER_MS;
	localparam logic [16:0] LAT_MUL = LAT_MUL_L[16:0];
	localparam logic [31:0] LAT_CNT_MAX = 32'hFFFF_FFFF;

	localparam tas_sig_s TAS_SIG_UNDEF = '{TAS_UNDEF, '0, '0};

endpackage

//--- design/tas_type_conv.sv
// Registered signal type converter with default substitution.
// Assumes the caller holds target kind and default steady per request.
`timescale 1ns/10ps
module tas_type_conv
	import tas_pkg::*;
(
	// Clock and reset
	input  wire logic      clk,
	input  wire logic      resetn,
	// Conversion request
	input  wire tas_sig_s  sig_in,
	input  wire tas_kind_e target,
	input  wire logic      dflt_en,
	input  wire tas_sig_s  dflt,
	// Result
	output tas_sig_s       sig_out
);

	tas_sig_s sig_q;
	tas_sig_s sig_d;
	tas_sig_s src;
	logic [IW-1:0] int_part;

	always_comb
	begin
		src = (sig_in.kind == TAS_UNDEF && dflt_en) ? dflt : sig_in;
		int_part = src.cont[CW-1:FRAC];
		sig_d = TAS_SIG_UNDEF;
		if (src.kind != TAS_UNDEF && target == TAS_CONT)
		begin
			sig_d.kind = TAS_CONT;
			if (src.kind == TAS_DISC)
				sig_d.cont = tas_cont_t'({src.disc, 16'h0000});
			else
				sig_d.cont = src.cont;
		end
		else if (src.kind != TAS_UNDEF && target == TAS_DISC)
		begin
			sig_d.kind = TAS_DISC;
			if (src.kind == TAS_DISC)
				sig_d.disc = src.disc;
			else if (src.cont < 0)
				sig_d.disc = '0;
			else if (int_part[IW-1:DW] != '0)
				sig_d.disc = TAS_DISC_MAX;
			else
				sig_d.disc = int_part[DW-1:0];
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			sig_q <= TAS_SIG_UNDEF;
		else
			sig_q <= sig_d;
	end

	assign sig_out = sig_q;

endmodule // tas_type_conv

//--- design/tas_trust_eval.sv
// Angular trust indicator evaluation.
// Assumes inputs are sampled only while data_valid is high.
`timescale 1ns/10ps
module tas_trust_eval
	import tas_pkg::*;
(
	// Clock and reset
	input  wire logic      clk,
	input  wire logic      resetn,
	// Conditions
	input  wire logic      data_valid,
	input  wire logic      sens_fault,
	input  wire tas_cont_t temp,
	input  wire tas_cont_t grav_err,
	input  wire tas_cont_t max_err,
	// Indicator
	output tas_sig_s       trust
);

	tas_sig_s trust_q;
	tas_sig_s trust_d;

	always_comb
	begin
		trust_d = trust_q;
		if (data_valid)
		begin
			trust_d.kind = TAS_DISC;
			trust_d.cont = '0;
			// Error tested first so it outranks suspect
			if (sens_fault || grav_err > max_err)
				trust_d.disc = TAS_TRUST_ERROR;
			else if (temp < TAS_TEMP_MIN || temp > TAS_TEMP_MAX)
				trust_d.disc = TAS_TRUST_SUSPECT;
			else
				trust_d.disc = TAS_TRUST_OK;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			trust_q <= TAS_SIG_UNDEF;
		else
			trust_q <= trust_d;
	end

	assign trust = trust_q;

endmodule // tas_trust_eval

//--- design/tas_core.sv
// Top of the tilt angle signal core: configuration, sensor outputs,
// angle range limiting, latency measurement and trust indication.
// Assumes the angle arithmetic sits outside and reports raw angles
// with a done pulse; all inputs are synchronous to clk.
`timescale 1ns/10ps
module tas_core
	import tas_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Variant straps, caught once after reset
	input  wire logic       strap_high_perf,
	input  wire logic       strap_vertical,
	// Configuration
	input  wire logic       cfg_load,
	input  wire tas_cfg_s   cfg_in,
	output tas_cfg_s        cfg_active,
	// Acceleration sensor
	input  wire logic       sens_valid,
	input  wire logic       sens_fault,
	input  wire tas_accel_s sens_data,
	output tas_range_e      sens_range,
	// Angle engine
	input  wire logic       ang_start,
	input  wire logic       ang_done,
	input  wire tas_raw_s   ang_raw,
	// Acceleration block outputs
	output tas_sig_s        acc_x,
	output tas_sig_s        acc_y,
	output tas_sig_s        acc_z,
	output tas_sig_s        acc_temp,
	// Angle block outputs
	output tas_sig_s        pitch_out,
	output tas_sig_s        roll_out,
	output tas_sig_s        grav_out,
	output tas_sig_s        grav_err_out,
	output tas_sig_s        latency_out,
	output tas_sig_s        trust_out,
	// Generic signal converter
	input  wire tas_sig_s   conv_in,
	input  wire tas_kind_e  conv_target,
	input  wire logic       conv_dflt_en,
	input  wire tas_sig_s   conv_dflt,
	output tas_sig_s        conv_out
);

	// Symmetric clamp of an angle to plus or minus lim
	function automatic tas_cont_t clamp_sym(
		input tas_cont_t v,
		input tas_cont_t lim
	);
		tas_cont_t r;
		r = v;
		if (v > lim)
			r = lim;
		else if (v < -lim)
			r = -lim;
		return r;
	endfunction

	// Clamp between two bounds
	function automatic tas_cont_t clamp_rng(
		input tas_cont_t v,
		input tas_cont_t lo,
		input tas_cont_t hi
	);
		tas_cont_t r;
		r = v;
		if (v < lo)
			r = lo;
		else if (v > hi)
			r = hi;
		return r;
	endfunction

	// Wrap a continuous value into a signal record
	function automatic tas_sig_s mk_cont(input tas_cont_t v);
		tas_sig_s s;
		s.kind = TAS_CONT;
		s.disc = '0;
		s.cont = v;
		return s;
	endfunction

	// Configuration and straps

	tas_cfg_s cfg_q;
	tas_cfg_s cfg_d;
	logic     strap_done_q;
	logic     strap_done_d;
	logic     high_perf_q;
	logic     high_perf_d;

	always_comb
	begin
		cfg_d        = cfg_q;
		strap_done_d = 1'b1;
		high_perf_d  = high_perf_q;
		if (!strap_done_q)
		begin
			// Straps sampled on the first edge after release, not at reset
			high_perf_d = strap_high_perf;
			if (strap_vertical)
				cfg_d.angle_type = TAS_ANG_EULER;
			else
				cfg_d.angle_type = TAS_ANG_TILT;
		end
		else if (cfg_load)
		begin
			cfg_d.angle_type = cfg_in.angle_type;
			if (cfg_in.angle_type != TAS_ANG_EULER &&
				cfg_in.angle_type != TAS_ANG_TILT &&
				cfg_in.angle_type != TAS_ANG_UNIT)
				cfg_d.angle_type = cfg_q.angle_type;
			cfg_d.tilt_range = cfg_in.tilt_range;
			cfg_d.max_err = clamp_rng(cfg_in.max_err,
				TAS_ERR_MIN, TAS_ERR_MAX);
			// Unknown range codes are refused and leave the range as is
			if (!high_perf_q)
				cfg_d.range = TAS_RANGE_DFLT;
			else if (cfg_in.range == TAS_RANGE_1G5 ||
				cfg_in.range == TAS_RANGE_3G ||
				cfg_in.range == TAS_RANGE_6G)
				cfg_d.range = cfg_in.range;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_q.range      <= TAS_RANGE_DFLT;
			cfg_q.angle_type <= TAS_ANG_TILT;
			cfg_q.tilt_range <= TAS_TILT_DFLT;
			cfg_q.max_err    <= TAS_ERR_DFLT;
			strap_done_q     <= 1'b0;
			high_perf_q      <= 1'b0;
		end
		else
		begin
			cfg_q        <= cfg_d;
			strap_done_q <= strap_done_d;
			high_perf_q  <= high_perf_d;
		end
	end

	assign cfg_active = cfg_q;
	assign sens_range = cfg_q.range;

	// Acceleration block

	tas_accel_s acc_q;
	tas_accel_s acc_d;
	logic       acc_ok_q;
	logic       acc_ok_d;

	always_comb
	begin
		acc_d    = acc_q;
		acc_ok_d = acc_ok_q;
		if (sens_valid)
		begin
			acc_d    = sens_data;
			acc_ok_d = 1'b1;
		end
		// A faulty sensor gives no signal until the next good sample
		if (sens_fault)
			acc_ok_d = 1'b0;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			acc_q    <= '0;
			acc_ok_q <= 1'b0;
		end
		else
		begin
			acc_q    <= acc_d;
			acc_ok_q <= acc_ok_d;
		end
	end

	assign acc_x    = acc_ok_q ? mk_cont(acc_q.x) : TAS_SIG_UNDEF;
	assign acc_y    = acc_ok_q ? mk_cont(acc_q.y) : TAS_SIG_UNDEF;
	assign acc_z    = acc_ok_q ? mk_cont(acc_q.z) : TAS_SIG_UNDEF;
	assign acc_temp = acc_ok_q ? mk_cont(acc_q.temp) : TAS_SIG_UNDEF;

	// Angle limiting

	tas_raw_s ang_q;
	tas_raw_s ang_d;
	logic     ang_ok_q;
	logic     ang_ok_d;
	tas_cont_t pitch_lim;
	tas_cont_t roll_lim;
	tas_cont_t tilt_lim;

	always_comb
	begin
		tilt_lim = (cfg_q.tilt_range == TAS_TILT_180) ?
			TAS_ANG_180 : TAS_ANG_90;
		case (cfg_q.angle_type)
			TAS_ANG_EULER:
			begin
				pitch_lim = TAS_ANG_90;
				roll_lim  = TAS_ANG_180;
			end
			TAS_ANG_UNIT:
			begin
				pitch_lim = TAS_ANG_180;
				roll_lim  = TAS_ANG_180;
			end
			TAS_ANG_TILT:
			begin
				pitch_lim = tilt_lim;
				roll_lim  = tilt_lim;
			end
			default:
			begin
				pitch_lim = TAS_ANG_90;
				roll_lim  = TAS_ANG_180;
			end
		endcase
		ang_d    = ang_q;
		ang_ok_d = ang_ok_q;
		if (ang_done)
		begin
			ang_d.pitch = clamp_sym(ang_raw.pitch, pitch_lim);
			ang_d.roll  = clamp_sym(ang_raw.roll, roll_lim);
			ang_d.grav  = clamp_rng(ang_raw.grav,
				TAS_ANG_0, TAS_ANG_180);
			// Error magnitude never reads negative
			ang_d.grav_err = (ang_raw.grav_err < 0) ?
				-ang_raw.grav_err : ang_raw.grav_err;
			ang_ok_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ang_q    <= '0;
			ang_ok_q <= 1'b0;
		end
		else
		begin
			ang_q    <= ang_d;
			ang_ok_q <= ang_ok_d;
		end
	end

	assign pitch_out    = ang_ok_q ? mk_cont(ang_q.pitch) : TAS_SIG_UNDEF;
	assign roll_out     = ang_ok_q ? mk_cont(ang_q.roll) : TAS_SIG_UNDEF;
	assign grav_out     = ang_ok_q ? mk_cont(ang_q.grav) : TAS_SIG_UNDEF;
	assign grav_err_out = ang_ok_q ? mk_cont(ang_q.grav_err) :
		TAS_SIG_UNDEF;

	// Latency from start to done, saturating after about 86 s

	logic [31:0] lat_cnt_q;
	logic [31:0] lat_cnt_d;
	logic        lat_run_q;
	logic        lat_run_d;
	tas_cont_t   lat_ms_q;
	tas_cont_t   lat_ms_d;
	logic        lat_ok_q;
	logic        lat_ok_d;
	logic [48:0] lat_prod;

	always_comb
	begin
		lat_cnt_d = lat_cnt_q;
		lat_run_d = lat_run_q;
		lat_ms_d  = lat_ms_q;
		lat_ok_d  = lat_ok_q;
		lat_prod  = lat_cnt_q * LAT_MUL;
		if (lat_run_q && lat_cnt_q != LAT_CNT_MAX)
			lat_cnt_d = lat_cnt_q + 32'h0000_0001;
		if (ang_done && lat_run_q)
		begin
			lat_ms_d  = tas_cont_t'(lat_prod[48:16]);
			lat_ok_d  = 1'b1;
			lat_run_d = 1'b0;
		end
		// A new start restarts the count, even on the done cycle
		if (ang_start)
		begin
			lat_cnt_d = 32'h0000_0001;
			lat_run_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lat_cnt_q <= '0;
			lat_run_q <= 1'b0;
			lat_ms_q  <= '0;
			lat_ok_q  <= 1'b0;
		end
		else
		begin
			lat_cnt_q <= lat_cnt_d;
			lat_run_q <= lat_run_d;
			lat_ms_q  <= lat_ms_d;
			lat_ok_q  <= lat_ok_d;
		end
	end

	assign latency_out = lat_ok_q ? mk_cont(lat_ms_q) : TAS_SIG_UNDEF;

	// Trust indicator and generic converter

	tas_trust_eval u_trust (
		.clk        (clk),
		.resetn     (resetn),
		.data_valid (ang_ok_q),
		.sens_fault (sens_fault || !acc_ok_q),
		.temp       (acc_q.temp),
		.grav_err   (ang_q.grav_err),
		.max_err    (cfg_q.max_err),
		.trust      (trust_out)
	);

	tas_type_conv u_conv (
		.clk     (clk),
		.resetn  (resetn),
		.sig_in  (conv_in),
		.target  (conv_target),
		.dflt_en (conv_dflt_en),
		.dflt    (conv_dflt),
		.sig_out (conv_out)
	);

endmodule // tas_core

//--- test/tas_core_sva.sv
// Concurrent checks on the ports of the tilt angle signal core.
// Assumes it is bound into tas_core and sees only that module's ports.
`timescale 1ns/10ps
module tas_core_sva
	import tas_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       resetn,
	// Watched ports
	input wire logic       sens_valid,
	input wire logic       sens_fault,
	input wire tas_accel_s sens_data,
	input wire tas_range_e sens_range,
	input wire tas_cfg_s   cfg_active,
	input wire logic       ang_done,
	input wire tas_sig_s   acc_x,
	input wire tas_sig_s   pitch_out,
	input wire tas_sig_s   roll_out,
	input wire tas_sig_s   grav_out,
	input wire tas_sig_s   trust_out,
	input wire tas_sig_s   conv_in,
	input wire tas_kind_e  conv_target,
	input wire tas_sig_s   conv_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	chk_range_follow: assert property (sens_range == cfg_active.range &&
		sens_range != 2'h3)
		else $error("sensor range differs from config or is illegal");
	chk_acc_sample: assert property (sens_valid && !sens_fault |=>
		acc_x.kind == TAS_CONT && acc_x.cont == $past(sens_data.x))
		else $error("acc_x not taken from sample");
	chk_fault_undef: assert property (sens_fault |=>
		acc_x.kind == TAS_UNDEF)
		else $error("acc_x defined during fault");
	chk_trust_fault: assert property (sens_fault &&
		trust_out.kind == TAS_DISC |=> trust_out.disc == TAS_TRUST_ERROR)
		else $error("trust not error during fault");
	chk_pitch_euler: assert property (ang_done &&
		cfg_active.angle_type == TAS_ANG_EULER |=>
		pitch_out.cont <= TAS_ANG_90 && pitch_out.cont >= -TAS_ANG_90)
		else $error("euler pitch out of span");
	chk_roll_span: assert property (roll_out.kind == TAS_CONT |->
		roll_out.cont <= TAS_ANG_180 && roll_out.cont >= -TAS_ANG_180)
		else $error("roll out of span");
	chk_grav_span: assert property (grav_out.kind == TAS_CONT |->
		grav_out.cont <= TAS_ANG_180 && grav_out.cont >= TAS_ANG_0)
		else $error("gravity angle out of span");
	chk_conv_undef: assert property (conv_target == TAS_UNDEF |=>
		conv_out.kind == TAS_UNDEF)
		else $error("undefined target gave a value");
	chk_disc_cont: assert property (conv_in.kind == TAS_DISC &&
		conv_target == TAS_CONT |=> conv_out.kind == TAS_CONT &&
		conv_out.cont == {8'h00, $past(conv_in.disc), 16'h0000})
		else $error("discrete to continuous wrong");
	chk_cont_trunc: assert property (conv_in.kind == TAS_CONT &&
		conv_in.cont[55:48] == 8'h00 && conv_target == TAS_DISC |=>
		conv_out.disc == $past(conv_in.cont[47:16]))
		else $error("continuous to discrete wrong");
	chk_cont_clamp: assert property (conv_in.kind == TAS_CONT &&
		!conv_in.cont[55] && conv_in.cont[54:48] != 7'h00 &&
		conv_target == TAS_DISC |=> conv_out.disc == TAS_DISC_MAX)
		else $error("large value not clamped");
	chk_cont_neg: assert property (conv_in.kind == TAS_CONT &&
		conv_in.cont[55] && conv_target == TAS_DISC |=>
		conv_out.disc == 32'h0000_0000)
		else $error("negative value not zero");
endmodule // tas_core_sva

bind tas_core tas_core_sva tas_core_sva_i (.clk, .resetn, .sens_valid,
	.sens_fault, .sens_data, .sens_range, .cfg_active, .ang_done, .acc_x,
	.pitch_out, .roll_out, .grav_out, .trust_out, .conv_in, .conv_target,
	.conv_out);

//--- test/tas_sens_model.sv
// Behavioural three-axis acceleration sensor.
// Assumes the bench asks for one sample per req pulse.
`timescale 1ns/10ps
module tas_sens_model
	import tas_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       resetn,
	// Bench side
	input wire logic       req,
	input wire logic       fail,
	input wire tas_accel_s truth,
	// Core side
	input wire tas_range_e range,
	output tas_accel_s     sens_data,
	output logic           sens_valid,
	output logic           sens_fault
);
	tas_cont_t lim;
	tas_cont_t x_sat;

	always_comb
	begin
		case (range)
			TAS_RANGE_3G: lim = 56'h00_0000_0003_0000;
			TAS_RANGE_6G: lim = 56'h00_0000_0006_0000;
			default:      lim = 56'h00_0000_0001_8000;
		endcase
		// A real sensor saturates at its range
		x_sat = (truth.x > lim) ? lim : truth.x;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sens_valid <= 1'b0;
			sens_fault <= 1'b0;
			sens_data  <= '0;
		end
		else
		begin
			sens_valid <= req;
			sens_fault <= fail;
			// Outside a sample the data is not held
			sens_data  <= req ?
				tas_accel_s'{x_sat, truth.y, truth.z, truth.temp} :
				~sens_data;
		end
	end
endmodule // tas_sens_model

//--- test/tb.sv
// Self-checking bench for the tilt angle signal core.
// Assumes tas_core, its bound checker and the sensor model are compiled.
`timescale 1ns/10ps
module tb
	import tas_pkg::*;
;
	localparam tas_cont_t G1   = 56'h00_0000_0001_0000;
	localparam tas_cont_t G15  = 56'h00_0000_0001_8000;
	localparam tas_cont_t G3   = 56'h00_0000_0003_0000;
	localparam tas_cont_t G5   = 56'h00_0000_0005_0000;
	localparam tas_cont_t D100 = 56'h00_0000_0064_0000;
	localparam tas_cont_t D200 = 56'h00_0000_00C8_0000;
	localparam tas_cont_t T25  = 56'h00_0000_0019_0000;
	localparam tas_cont_t T130 = 56'h00_0000_0082_0000;
	localparam tas_cont_t E_OK = 56'h00_0000_0000_1999;
	localparam int        LN   = 100;

	logic       clk, resetn, strap_high_perf, strap_vertical, cfg_load;
	logic       ang_start, ang_done, conv_dflt_en, req, fail;
	logic       sens_valid, sens_fault;
	tas_cfg_s   cfg_in, cfg_active;
	tas_accel_s sens_data, truth;
	tas_range_e sens_range;
	tas_raw_s   ang_raw;
	tas_kind_e  conv_target;
	tas_sig_s   acc_x, acc_temp, pitch_out, roll_out, grav_out;
	tas_sig_s   acc_y, acc_z, grav_err_out;
	tas_sig_s   latency_out, trust_out, conv_in, conv_dflt, conv_out;
	tas_cont_t  lat;
	int         n_errors, compares;
	tas_angle_e at[4] = '{TAS_ANG_EULER, TAS_ANG_UNIT, TAS_ANG_TILT,
		TAS_ANG_TILT};
	tas_tilt_e  tl[4] = '{TAS_TILT_90, TAS_TILT_90, TAS_TILT_90, TAS_TILT_180};
	tas_cont_t  ep[4] = '{-TAS_ANG_90, -D100, -TAS_ANG_90, -D100};
	tas_cont_t  er[4] = '{TAS_ANG_180, TAS_ANG_180, TAS_ANG_90, TAS_ANG_180};

	tas_core tas_core_i (.clk, .resetn, .strap_high_perf, .strap_vertical,
		.cfg_load, .cfg_in, .cfg_active, .sens_valid, .sens_fault, .sens_data,
		.sens_range, .ang_start, .ang_done, .ang_raw, .acc_x, .acc_y,
		.acc_z, .acc_temp, .pitch_out, .roll_out, .grav_out,
		.grav_err_out, .latency_out, .trust_out, .conv_in, .conv_target,
		.conv_dflt_en, .conv_dflt, .conv_out);
	tas_sens_model tas_sens_model_i (.clk, .resetn, .req, .fail, .truth,
		.range(sens_range), .sens_data, .sens_valid, .sens_fault);

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic tas_sig_s sd(input tas_disc_t v);
		return '{TAS_DISC, v, '0};
	endfunction
	function automatic tas_sig_s sc(input tas_cont_t v);
		return '{TAS_CONT, '0, v};
	endfunction

	task automatic chk(input string nm, input logic [127:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim;
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic settle;
		@(posedge clk);
		#1;
	endtask
	task automatic rst(input logic hp, vt);
		@(posedge clk);
		resetn <= 1'b0;
		strap_high_perf <= hp;
		strap_vertical <= vt;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic load(input tas_range_e r, input tas_angle_e a,
		input tas_tilt_e t, input tas_cont_t e);
		@(posedge clk);
		cfg_load <= 1'b1;
		cfg_in <= '{r, a, t, e};
		@(posedge clk);
		cfg_load <= 1'b0;
		#1;
	endtask
	task automatic samp(input tas_cont_t x, t, input logic f);
		@(posedge clk);
		req <= 1'b1;
		fail <= f;
		truth <= '{x, '0, G1, t};
		@(posedge clk);
		req <= 1'b0;
		settle();
	endtask
	task automatic ang(input tas_cont_t e);
		@(posedge clk);
		ang_done <= 1'b1;
		ang_raw <= '{-D100, D200, -D100, e};
		@(posedge clk);
		ang_done <= 1'b0;
		#1;
	endtask
	task automatic tr(input tas_disc_t v);
		settle();
		chk("trust_out", trust_out, sd(v));
	endtask
	task automatic cv(input tas_sig_s i, x, input tas_kind_e k,
		input logic de = 1'b0, input tas_sig_s d = TAS_SIG_UNDEF);
		@(posedge clk);
		conv_in <= i;
		conv_target <= k;
		conv_dflt_en <= de;
		conv_dflt <= d;
		settle();
		chk("conv_out", conv_out, x);
	endtask

	initial
	begin
		n_errors = 0;
		compares = 0;
		{resetn, strap_high_perf, strap_vertical, cfg_load} = 4'h0;
		{ang_start, ang_done, conv_dflt_en, req, fail} = 5'h00;
		{cfg_in, truth, ang_raw, conv_in, conv_dflt} = '0;
		conv_target = TAS_UNDEF;
		rst(1'b0, 1'b0);
		chk("cfg_active", cfg_active, tas_cfg_s'{TAS_RANGE_1G5, TAS_ANG_TILT,
			TAS_TILT_90, TAS_ERR_DFLT});
		chk("trust_kind", trust_out.kind, TAS_UNDEF);
		chk("latency_kind", latency_out.kind, TAS_UNDEF);
		samp(G5, T25, 1'b0);
		chk("acc_x", acc_x, sc(G15));
		chk("acc_y", acc_y, sc('0));
		chk("acc_z", acc_z, sc(G1));
		chk("acc_temp", acc_temp, sc(T25));
		for (int i = 0; i < 4; i++)
		begin
			load(TAS_RANGE_1G5, at[i], tl[i], TAS_ERR_DFLT);
			ang(E_OK);
			chk("pitch_out", pitch_out, sc(ep[i]));
			chk("roll_out", roll_out, sc(er[i]));
		end
		chk("grav_out", grav_out, sc(TAS_ANG_0));
		chk("grav_err_out", grav_err_out, sc(E_OK));
		tr(TAS_TRUST_OK);
		samp(G1, T130, 1'b0);
		tr(TAS_TRUST_SUSPECT);
		// Error equal to the limit is not an excess
		load(TAS_RANGE_1G5, TAS_ANG_TILT, TAS_TILT_90, '0);
		chk("max_err", cfg_active.max_err, TAS_ERR_MIN);
		ang(TAS_ERR_MIN);
		tr(TAS_TRUST_SUSPECT);
		ang(TAS_ERR_MIN + 56'h00_0000_0000_0001);
		tr(TAS_TRUST_ERROR);
		samp(G1, T25, 1'b1);
		chk("acc_x_kind", acc_x.kind, TAS_UNDEF);
		tr(TAS_TRUST_ERROR);
		load(TAS_RANGE_6G, TAS_ANG_EULER, TAS_TILT_90, G1);
		chk("cfg_active", cfg_active, tas_cfg_s'{TAS_RANGE_1G5, TAS_ANG_EULER,
			TAS_TILT_90, TAS_ERR_MAX});
		@(posedge clk);
		ang_start <= 1'b1;
		@(posedge clk);
		ang_start <= 1'b0;
		repeat (LN - 2) @(posedge clk);
		ang(E_OK);
		lat = tas_cont_t'((LN * 64'h0001_4F8B) >> 16);
		chk("latency_out", latency_out, sc(lat));
		cv(sd(32'h0000_0005), sc(G5), TAS_CONT);
		cv(sc(56'h00_0000_0003_C000), sd(32'h0000_0003), TAS_DISC);
		cv(sc(56'h02_0000_0000_0000), sd(TAS_DISC_MAX), TAS_DISC);
		cv(sc(-G1), sd(32'h0000_0000), TAS_DISC);
		cv(TAS_SIG_UNDEF, sc(56'h00_0000_0007_0000), TAS_CONT, 1'b1,
			sd(32'h0000_0007));
		cv(TAS_SIG_UNDEF, TAS_SIG_UNDEF, TAS_DISC);
		rst(1'b1, 1'b1);
		chk("angle_type", cfg_active.angle_type, TAS_ANG_EULER);
		// Saturation case: range raised only for strong vibration
		load(TAS_RANGE_6G, TAS_ANG_UNIT, TAS_TILT_90, TAS_ERR_DFLT);
		chk("sens_range", sens_range, TAS_RANGE_6G);
		samp(G5, T25, 1'b0);
		chk("acc_x", acc_x, sc(G5));
		load(TAS_RANGE_3G, TAS_ANG_UNIT, TAS_TILT_90, TAS_ERR_DFLT);
		chk("sens_range", sens_range, TAS_RANGE_3G);
		samp(G5, T25, 1'b0);
		chk("acc_x", acc_x, sc(G3));
		end_sim();
	end
endmodule // tb
